//--- rtl/sio_defs.svh
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH

// ----------------------------------------
// register indices, byte address = 4 x index
// ----------------------------------------
`define SIO_IDX_CTRL 6'h15
`define SIO_IDX_STAT 6'h16
`define SIO_IDX_DATA 6'h17
`define SIO_IDX_IEN 6'h1A
`define SIO_IDX_RATE 6'h1B

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define SIO_ST_WAKE 4
`define SIO_ST_EOT 5

// ----------------------------------------
// interrupt enable bit positions
// ----------------------------------------
`define SIO_IEN_RX 0
`define SIO_IEN_TX 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define SIO_CTRL_RST 8'h00
`define SIO_IEN_RST 8'h00
`define SIO_RATE_RST 16'h0000

// ----------------------------------------
// timing counts
// ----------------------------------------
`define SIO_PH_LAST 4'hF
`define SIO_PH_HALF 4'h8
`define SIO_SUB_HALF 3'h3
`define SIO_SUB_LAST 3'h7
`define SIO_IDLE_SUBS 7'h50

// ----------------------------------------
// bus responses
// ----------------------------------------
`define SIO_RESP_OKAY 2'h0
`define SIO_RESP_SLVERR 2'h2

`endif

//--- rtl/sio_pkg.sv
package sio_pkg;

  // ----------------------------------------
  // control register layout
  // ----------------------------------------
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic rx_shift;
    logic tx_shift;
    logic [1:0] len;
    logic par_en;
    logic par_odd;
  } ctrl_t;

  // ----------------------------------------
  // status register layout
  // ----------------------------------------
  typedef struct packed {
    logic urun;
    logic tdre;
    logic eot;
    logic wake;
    logic fe;
    logic pe;
    logic ovr;
    logic full;
  } status_t;

  // ----------------------------------------
  // receiver states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_SHIFT = 2'b11
  } rx_state_t;

endpackage

//--- rtl/serial_io_channel.sv
`timescale 1ns/1ps
`include "sio_defs.svh"

module serial_io_channel (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // serial pins
  output logic tx_pin,
  input wire logic rx_pin,
  // counter a line, two-way
  input wire logic counter_a_line_i,
  output logic counter_a_line_o,
  output logic counter_a_line_oe_n,
  // counter a mode
  input wire logic [1:0] cnt_a_mode_in,
  output logic [1:0] cnt_a_mode_out,
  output logic cnt_a_force_interval,
  // interrupt flags and requests
  output logic rx_irq_flag,
  output logic tx_irq_flag,
  output logic rx_irq_req,
  output logic tx_irq_req
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  sio_pkg::ctrl_t ctrl_q;
  sio_pkg::status_t stat_q;
  sio_pkg::rx_state_t rx_state_q;
  logic [7:0] ien_q;
  logic [15:0] rate_q;
  logic [15:0] rate_cnt_q;
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic rd_go;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_hit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic rd_clr;
  logic need_int;
  logic uf;
  logic [7:0] txd_q;
  logic [11:0] tx_sr_q;
  logic [11:0] tx_frame;
  logic [3:0] tx_len;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_ph_q;
  logic tx_busy_q;
  logic tx_sm_q;
  logic tx_clk_q;
  logic tx_load;
  logic tx_done;
  logic [7:0] len_mask;
  logic rx_s1;
  logic rx_s2;
  logic ca_s1;
  logic ca_s2;
  logic ca_prev_q;
  logic rx_half_q;
  logic sub;
  logic [2:0] sub_cnt_q;
  logic [3:0] bit_idx_q;
  logic [3:0] rx_total;
  logic [9:0] rx_sr_q;
  logic [7:0] rx_data_q;
  logic [6:0] ones_q;
  logic idle_det;
  logic rx_xfer;
  logic [7:0] rx_new;
  logic rx_pe;
  logic rx_fe;
  logic tdre_vis;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_go = aw_q && w_q && !bvalid_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign wr_idx = awaddr_q[7:2];
  assign rd_idx = s_axi_araddr[7:2];
  assign wr_hit = wr_idx == `SIO_IDX_CTRL || wr_idx == `SIO_IDX_STAT ||
                  wr_idx == `SIO_IDX_DATA || wr_idx == `SIO_IDX_IEN ||
                  wr_idx == `SIO_IDX_RATE;
  assign wr_ctrl = wr_go && wstrb_q[0] && wr_idx == `SIO_IDX_CTRL;
  assign wr_stat = wr_go && wstrb_q[0] && wr_idx == `SIO_IDX_STAT;
  assign wr_data = wr_go && wstrb_q[0] && wr_idx == `SIO_IDX_DATA;
  assign rd_clr = rd_go && rd_idx == `SIO_IDX_DATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SIO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `SIO_RESP_OKAY : `SIO_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SIO_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= `SIO_RESP_OKAY;
      if (rd_idx == `SIO_IDX_CTRL) begin
        rdata_q <= {24'h000000, ctrl_q};
      end else if (rd_idx == `SIO_IDX_STAT) begin
        rdata_q <= {24'h000000, stat_q};
      end else if (rd_idx == `SIO_IDX_DATA) begin
        rdata_q <= {24'h000000, rx_data_q};
      end else if (rd_idx == `SIO_IDX_IEN) begin
        rdata_q <= {24'h000000, ien_q};
      end else if (rd_idx == `SIO_IDX_RATE) begin
        rdata_q <= {16'h0000, rate_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= `SIO_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `SIO_CTRL_RST;
      ien_q <= `SIO_IEN_RST;
      rate_q <= `SIO_RATE_RST;
      txd_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
      end
      if (wr_go && wr_idx == `SIO_IDX_IEN && wstrb_q[0]) begin
        ien_q <= wdata_q[7:0];
      end
      if (wr_go && wr_idx == `SIO_IDX_RATE) begin
        if (wstrb_q[0]) begin
          rate_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          rate_q[15:8] <= wdata_q[15:8];
        end
      end
      if (wr_data) begin
        txd_q <= wdata_q[7:0];
      end
    end
  end

  // ----------------------------------------
  // counter a rate source
  // ----------------------------------------
  assign need_int = ctrl_q.tx_en || (ctrl_q.rx_en && !ctrl_q.rx_shift);
  assign uf = need_int && rate_cnt_q == 16'h0000;
  assign cnt_a_force_interval = need_int;
  assign cnt_a_mode_out = need_int ? 2'h0 : cnt_a_mode_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt_q <= `SIO_RATE_RST;
    end else if (!need_int || uf) begin
      rate_cnt_q <= rate_q;
    end else begin
      rate_cnt_q <= rate_cnt_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  assign len_mask = 8'hFF >> (2'h3 - ctrl_q.len);
  assign tx_len = ctrl_q.tx_shift ? 4'h8 : {2'b00, ctrl_q.len} + 4'h8;
  assign tx_load = ctrl_q.tx_en && !tx_busy_q && !stat_q.tdre;
  assign tx_done = uf && tx_busy_q && tx_ph_q == `SIO_PH_LAST && tx_cnt_q == 4'h1;

  always_comb begin
    tx_frame = 12'hFFF;
    if (ctrl_q.tx_shift) begin
      tx_frame[7:0] = txd_q;
    end else begin
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < int'(ctrl_q.len) + 5) begin
          tx_frame[i + 1] = txd_q[i];
        end
      end
      if (ctrl_q.par_en) begin
        tx_frame[int'(ctrl_q.len) + 6] = ^(txd_q & len_mask) ^ ctrl_q.par_odd;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sr_q <= 12'hFFF;
      tx_cnt_q <= 4'h0;
      tx_ph_q <= 4'h0;
      tx_busy_q <= 1'b0;
      tx_sm_q <= 1'b0;
    end else if (!ctrl_q.tx_en) begin
      tx_sr_q <= 12'hFFF;
      tx_busy_q <= 1'b0;
    end else if (tx_load) begin
      tx_sr_q <= tx_frame;
      tx_cnt_q <= tx_len - (ctrl_q.tx_shift ? 4'h0 : {3'b000, ctrl_q.par_en});
      tx_ph_q <= 4'h0;
      tx_busy_q <= 1'b1;
      tx_sm_q <= ctrl_q.tx_shift;
    end else if (uf && tx_busy_q) begin
      tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_ph_q == `SIO_PH_LAST) begin
        tx_sr_q <= {1'b1, tx_sr_q[11:1]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
        if (tx_cnt_q == 4'h1) begin
          tx_busy_q <= 1'b0;
          tx_sr_q <= 12'hFFF;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_clk_q <= 1'b1;
    end else begin
      tx_clk_q <= !(tx_busy_q && tx_sm_q && tx_ph_q < `SIO_PH_HALF);
    end
  end

  assign tx_pin = tx_sr_q[0];
  assign counter_a_line_o = tx_clk_q;
  assign counter_a_line_oe_n = !(ctrl_q.tx_en && ctrl_q.tx_shift);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      ca_s1 <= 1'b1;
      ca_s2 <= 1'b1;
      ca_prev_q <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      ca_s1 <= counter_a_line_i;
      ca_s2 <= ca_s1;
      ca_prev_q <= ca_s2;
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign sub = uf && rx_half_q;
  assign rx_total = {2'b00, ctrl_q.len} + 4'h6 + {3'b000, ctrl_q.par_en};
  assign idle_det = sub && rx_s2 && ones_q == `SIO_IDLE_SUBS - 7'h01;
  assign rx_new = rx_sr_q[7:0] & (ctrl_q.rx_shift ? 8'hFF : len_mask);
  assign rx_pe = ctrl_q.par_en &&
                 (^rx_new ^ ctrl_q.par_odd ^ rx_sr_q[int'(ctrl_q.len) + 5]);
  assign rx_fe = !rx_sr_q[rx_total - 4'h1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_half_q <= 1'b0;
      ones_q <= 7'h00;
    end else begin
      if (uf) begin
        rx_half_q <= !rx_half_q;
      end
      if (!rx_s2 || !ctrl_q.rx_en || ctrl_q.rx_shift) begin
        ones_q <= 7'h00;
      end else if (sub && ones_q != `SIO_IDLE_SUBS) begin
        ones_q <= ones_q + 7'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= sio_pkg::RX_IDLE;
      sub_cnt_q <= 3'h0;
      bit_idx_q <= 4'h0;
      rx_sr_q <= 10'h000;
      rx_xfer <= 1'b0;
    end else begin
      rx_xfer <= 1'b0;
      if (!ctrl_q.rx_en) begin
        rx_state_q <= sio_pkg::RX_IDLE;
        bit_idx_q <= 4'h0;
      end else begin
        case (rx_state_q)
          sio_pkg::RX_IDLE: begin
            sub_cnt_q <= 3'h0;
            bit_idx_q <= 4'h0;
            if (ctrl_q.rx_shift) begin
              rx_state_q <= sio_pkg::RX_SHIFT;
            end else if (!rx_s2) begin
              rx_state_q <= sio_pkg::RX_START;
            end
          end
          sio_pkg::RX_START: begin
            if (sub) begin
              sub_cnt_q <= sub_cnt_q + 3'h1;
              if (sub_cnt_q == `SIO_SUB_HALF) begin
                sub_cnt_q <= 3'h0;
                rx_state_q <= rx_s2 ? sio_pkg::RX_IDLE : sio_pkg::RX_BITS;
              end
            end
          end
          sio_pkg::RX_BITS: begin
            if (sub) begin
              sub_cnt_q <= sub_cnt_q + 3'h1;
              if (sub_cnt_q == `SIO_SUB_LAST) begin
                rx_sr_q[bit_idx_q] <= rx_s2;
                bit_idx_q <= bit_idx_q + 4'h1;
                if (bit_idx_q == rx_total - 4'h1) begin
                  rx_xfer <= 1'b1;
                  rx_state_q <= sio_pkg::RX_IDLE;
                end
              end
            end
          end
          sio_pkg::RX_SHIFT: begin
            if (!ctrl_q.rx_shift) begin
              rx_state_q <= sio_pkg::RX_IDLE;
            end else if (ca_s2 && !ca_prev_q) begin
              rx_sr_q[bit_idx_q] <= rx_s2;
              bit_idx_q <= bit_idx_q + 4'h1;
              if (bit_idx_q == 4'h7) begin
                bit_idx_q <= 4'h0;
                rx_xfer <= 1'b1;
              end
            end
          end
          default: begin
            rx_state_q <= sio_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_q <= 8'h00;
      stat_q <= '0;
      stat_q.tdre <= 1'b1;
    end else begin
      if (rx_xfer && !stat_q.wake) begin
        rx_data_q <= rx_new;
      end
      if (!ctrl_q.rx_en) begin
        stat_q.full <= 1'b0;
        stat_q.ovr <= 1'b0;
        stat_q.pe <= 1'b0;
        stat_q.fe <= 1'b0;
      end else if (rx_xfer && !stat_q.wake) begin
        if (stat_q.full) begin
          stat_q.ovr <= 1'b1;
        end else if (rd_clr) begin
          stat_q.ovr <= 1'b0;
        end
        if (!ctrl_q.rx_shift && rx_pe) begin
          stat_q.pe <= 1'b1;
        end else if (rd_clr) begin
          stat_q.pe <= 1'b0;
        end
        if (!ctrl_q.rx_shift && rx_fe) begin
          stat_q.fe <= 1'b1;
        end else if (rd_clr) begin
          stat_q.fe <= 1'b0;
        end
        if (ctrl_q.rx_shift || (!rx_pe && !rx_fe)) begin
          stat_q.full <= 1'b1;
        end else if (rd_clr) begin
          stat_q.full <= 1'b0;
        end
      end else if (rd_clr) begin
        stat_q.full <= 1'b0;
        stat_q.ovr <= 1'b0;
        stat_q.pe <= 1'b0;
        stat_q.fe <= 1'b0;
      end
      if (wr_stat && wdata_q[`SIO_ST_WAKE]) begin
        stat_q.wake <= 1'b1;
      end else if (idle_det) begin
        stat_q.wake <= 1'b0;
      end
      if (wr_stat && wdata_q[`SIO_ST_EOT]) begin
        stat_q.eot <= 1'b1;
      end else if (wr_data) begin
        stat_q.eot <= 1'b0;
      end
      if (wr_data) begin
        stat_q.tdre <= 1'b0;
      end else if (tx_load) begin
        stat_q.tdre <= 1'b1;
      end
      if (tx_done && stat_q.tdre) begin
        stat_q.urun <= 1'b1;
      end else if (tx_load) begin
        stat_q.urun <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  assign tdre_vis = stat_q.tdre && (!stat_q.eot || stat_q.urun);
  assign tx_irq_flag = ctrl_q.tx_en && (tdre_vis || stat_q.urun);
  assign rx_irq_flag = stat_q.full || stat_q.ovr || stat_q.pe || stat_q.fe;
  assign rx_irq_req = rx_irq_flag && ien_q[`SIO_IEN_RX];
  assign tx_irq_req = tx_irq_flag && ien_q[`SIO_IEN_TX];

endmodule

//--- bench/serial_io_channel_monitor.sv
`timescale 1ns/1ps
module serial_io_channel_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus read side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // pins, counter a mode and flags
  input wire logic tx_pin,
  input wire logic counter_a_line_o,
  input wire logic [1:0] cnt_a_mode_in,
  input wire logic [1:0] cnt_a_mode_out,
  input wire logic cnt_a_force_interval,
  input wire logic rx_irq_flag,
  input wire logic tx_irq_flag,
  input wire logic rx_irq_req,
  input wire logic tx_irq_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------
  // checks
  // ----------------
  force_mode_a: assert property (cnt_a_force_interval |-> cnt_a_mode_out == 2'h0)
    else $error("counter a mode not forced");
  pass_mode_a: assert property (!cnt_a_force_interval |-> cnt_a_mode_out == cnt_a_mode_in)
    else $error("counter a mode altered");
  start_len_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
    else $error("serial low level too short");
  shift_clk_a: assert property ($fell(counter_a_line_o) |-> !counter_a_line_o [*8])
    else $error("shift clock low phase too short");
  idle_high_a: assert property ($rose(aresetn) |-> tx_pin && counter_a_line_o)
    else $error("lines not idle high after reset");
  rx_req_a: assert property (rx_irq_req |-> rx_irq_flag)
    else $error("receive request without flag");
  tx_req_a: assert property (tx_irq_req |-> tx_irq_flag)
    else $error("transmit request without flag");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule

bind serial_io_channel serial_io_channel_monitor u_serial_io_channel_monitor (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .tx_pin,
  .counter_a_line_o, .cnt_a_mode_in, .cnt_a_mode_out, .cnt_a_force_interval,
  .rx_irq_flag, .tx_irq_flag, .rx_irq_req, .tx_irq_req
);

//--- bench/sio_peer.sv
`timescale 1ns/1ps
module sio_peer #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input wire logic aclk,
  // serial lines
  output logic rx_line,
  output logic clk_line
);
  initial begin
    rx_line = 1'h1;
    clk_line = 1'h1;
  end
  // ----------------
  // frame sender
  // ----------------
  task automatic hold(input logic v);
    rx_line <= v;
    repeat (BIT_CYCLES) @(posedge aclk);
  endtask
  task automatic send(input logic [7:0] d, input logic p_en, input logic p, input logic stop);
    @(posedge aclk);
    hold(1'h0);
    for (int i = 0; i < 8; i++) begin
      hold(d[i]);
    end
    if (p_en) begin
      hold(p);
    end
    hold(stop);
    rx_line <= 1'h1;
  endtask
  task automatic shift(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      clk_line <= 1'h0;
      rx_line <= d[i];
      repeat (BIT_CYCLES / 2) @(posedge aclk);
      clk_line <= 1'h1;
      repeat (BIT_CYCLES / 2) @(posedge aclk);
    end
    rx_line <= 1'h1;
  endtask
  task automatic pulse();
    @(posedge aclk);
    rx_line <= 1'h0;
    repeat (4) @(posedge aclk);
    rx_line <= 1'h1;
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "sio_defs.svh"
module tb_top;
  localparam logic [7:0] A_CTRL = {`SIO_IDX_CTRL, 2'h0};
  localparam logic [7:0] A_STAT = {`SIO_IDX_STAT, 2'h0};
  localparam logic [7:0] A_DATA = {`SIO_IDX_DATA, 2'h0};
  localparam logic [7:0] A_IEN = {`SIO_IDX_IEN, 2'h0};
  localparam logic [7:0] A_RATE = {`SIO_IDX_RATE, 2'h0};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, cnt_a_mode_in, cnt_a_mode_out, resp;
  logic tx_pin, rx_pin, cnt_in, cnt_o, cnt_oe_n, cnt_force, peer_clk;
  logic rx_irq_flag, tx_irq_flag, rx_irq_req, tx_irq_req;
  logic [10:0] frame;
  int miscompares, cmp_count, cycles;
  assign cnt_in = cnt_oe_n ? peer_clk : cnt_o;
  serial_io_channel u_serial_io_channel (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_pin, .rx_pin,
    .counter_a_line_i(cnt_in), .counter_a_line_o(cnt_o), .counter_a_line_oe_n(cnt_oe_n),
    .cnt_a_mode_in, .cnt_a_mode_out, .cnt_a_force_interval(cnt_force),
    .rx_irq_flag, .tx_irq_flag, .rx_irq_req, .tx_irq_req
  );
  sio_peer u_sio_peer (.aclk, .rx_line(rx_pin), .clk_line(peer_clk));
  // ----------------
  // bus and compare tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ar, r;
    r = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (r) s_axi_rready <= 1'h0;
    end
  endtask
  task automatic stat(input logic [3:0] e);
    rd_reg(A_STAT);
    check(rd & 32'hF, {28'h0, e});
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // ----------------
  // scenarios
  // ----------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    cnt_a_mode_in = 2'h3;
    {miscompares, cmp_count, cycles} = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd_reg(A_STAT);
    check(rd, 32'h40);
    rd_reg(8'h00);
    check({rd[29:0], resp}, {30'h0, `SIO_RESP_SLVERR});
    wr_reg(8'h00, 32'h0);
    check({30'h0, resp}, {30'h0, `SIO_RESP_SLVERR});
    wr_reg(A_RATE, 32'h0);
    check({30'h0, resp}, {30'h0, `SIO_RESP_OKAY});
    wr_reg(A_CTRL, 32'h8C);
    check({30'h0, cnt_a_mode_out}, 32'h0);
    wr_reg(A_STAT, 32'h20);
    rd_reg(A_STAT);
    check({rd[30:0], tx_irq_flag}, {31'h60, 1'h0});
    wr_reg(A_DATA, 32'hA5);
    rd_reg(A_STAT);
    check(rd, 32'h40);
    while (tx_pin !== 1'h0) @(negedge aclk);
    repeat (8) @(negedge aclk);
    for (int i = 0; i < 11; i++) begin
      frame[i] = tx_pin;
      repeat (16) @(negedge aclk);
    end
    check({21'h0, frame}, {21'h0, 2'h3, 8'hA5, 1'h0});
    rd_reg(A_STAT);
    check({rd[30:0], tx_irq_flag}, {31'hC0, 1'h1});
    wr_reg(A_CTRL, 32'hCC);
    wr_reg(A_IEN, 32'h1);
    u_sio_peer.send(8'h3C, 1'h0, 1'h0, 1'h1);
    stat(4'h1);
    check({29'h0, rx_irq_flag, rx_irq_req, tx_irq_req}, 32'h6);
    rd_reg(A_DATA);
    check(rd, 32'h3C);
    stat(4'h0);
    u_sio_peer.send(8'h11, 1'h0, 1'h0, 1'h1);
    u_sio_peer.send(8'h22, 1'h0, 1'h0, 1'h1);
    stat(4'h3);
    rd_reg(A_DATA);
    stat(4'h0);
    u_sio_peer.pulse();
    repeat (200) @(posedge aclk);
    stat(4'h0);
    wr_reg(A_CTRL, 32'hCE);
    u_sio_peer.send(8'h01, 1'h1, 1'h0, 1'h1);
    stat(4'h4);
    rd_reg(A_DATA);
    u_sio_peer.send(8'h01, 1'h1, 1'h1, 1'h1);
    stat(4'h1);
    rd_reg(A_DATA);
    fork
      u_sio_peer.send(8'h33, 1'h0, 1'h0, 1'h1);
      begin
        repeat (40) @(posedge aclk);
        wr_reg(A_STAT, 32'h10);
      end
    join
    rd_reg(A_STAT);
    check(rd & 32'h1F, 32'h10);
    repeat (200) @(posedge aclk);
    u_sio_peer.send(8'h44, 1'h1, 1'h0, 1'h1);
    rd_reg(A_STAT);
    check(rd & 32'h1F, 32'h1);
    rd_reg(A_DATA);
    wr_reg(A_CTRL, 32'h8C);
    u_sio_peer.send(8'h66, 1'h0, 1'h0, 1'h1);
    stat(4'h0);
    rd_reg(A_DATA);
    check(rd, 32'h44);
    wr_reg(A_CTRL, 32'h4C);
    wr_reg(A_DATA, 32'h5A);
    repeat (20) @(posedge aclk);
    check({30'h0, tx_pin, tx_irq_flag}, 32'h2);
    wr_reg(A_CTRL, 32'h92);
    check({31'h0, cnt_oe_n}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      while (cnt_o !== 1'h0) @(negedge aclk);
      while (cnt_o !== 1'h1) @(negedge aclk);
      frame[i] = tx_pin;
    end
    check({24'h0, frame[7:0]}, 32'h5A);
    repeat (40) @(posedge aclk);
    check({30'h0, tx_pin, cnt_o}, 32'h3);
    wr_reg(A_CTRL, 32'h0);
    u_sio_peer.send(8'h21, 1'h0, 1'h0, 1'h0);
    check({30'h0, cnt_a_mode_out}, 32'h3);
    wr_reg(A_CTRL, 32'h6C);
    u_sio_peer.shift(8'hC3);
    stat(4'h1);
    rd_reg(A_DATA);
    check(rd, 32'hC3);
    wr_reg(A_CTRL, 32'h4C);
    u_sio_peer.send(8'h55, 1'h0, 1'h0, 1'h0);
    rd_reg(A_STAT);
    check(rd & 32'h8, 32'h8);
    finish_test();
  end
endmodule
